// ===== core/alarm_status_and_fuse_readback.sv
/*
  Alarm status, clock-loss detection, output mid-scale forcing and
  temperature/fuse readback, reached over the serial configuration port.
  Assumes serial port pins and clock-loss probes are asynchronous (synced
  here), while samples, check results and interpolation come from
  core_clk logic. Fuse pins are static after power-up.
*/
`timescale 1ns/1ps
`default_nettype none
module alarm_status_and_fuse_readback
  import alarm_fuse_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int GONE_BASE = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdenb_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic sample_clk_probe,
  input wire logic data_clk_probe,
  input wire logic [1:0] interp_sel,
  input wire logic check_a_valid,
  input wire logic check_a_mismatch,
  input wire logic check_b_valid,
  input wire logic check_b_mismatch,
  input wire logic [7:0] temp_code,
  input wire logic [5:0] fuse_pins,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  output logic [15:0] output_serializer_a,
  output logic [15:0] output_serializer_b,
  output logic alarm_pin,
  output logic force_full_word,
  output logic force_single_conv,
  output logic [1:0] force_resolution
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_INSTR = 3'b010,
    S_DATA = 3'b100
  } port_state_t;

  // Two-flop synchronisers for every asynchronous pin
  logic sclk_m, sclk_s, enb_m, enb_s, sdi_m, sdi_s;
  logic sck_m, sck_s, dck_m, dck_s;
  logic [7:0] temp_m, temp_s, temp_p, temp_word;
  logic sclk_q, sck_q, dck_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_m <= '0;
      sclk_s <= '0;
      enb_m <= 1'b1;
      enb_s <= 1'b1;
      sdi_m <= '0;
      sdi_s <= '0;
      sck_m <= '0;
      sck_s <= '0;
      dck_m <= '0;
      dck_s <= '0;
      temp_m <= TEMP_RESET;
      temp_s <= TEMP_RESET;
      sclk_q <= 1'b0;
      sck_q <= 1'b0;
      dck_q <= 1'b0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      enb_m <= sdenb_n;
      enb_s <= enb_m;
      sdi_m <= sdi;
      sdi_s <= sdi_m;
      sck_m <= sample_clk_probe;
      sck_s <= sck_m;
      dck_m <= data_clk_probe;
      dck_s <= dck_m;
      temp_m <= temp_code;
      temp_s <= temp_m;
      sclk_q <= sclk_s;
      sck_q <= sck_s;
      dck_q <= dck_s;
    end
  end

  // Bitwise-synced sensor word may tear; keep it only once it repeats
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temp_p <= TEMP_RESET;
      temp_word <= TEMP_RESET;
    end else begin
      temp_p <= temp_s;
      if (temp_s == temp_p) begin
        temp_word <= temp_s;
      end
    end
  end

  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire frame_on = ~enb_s;
  wire sck_edge = sck_s ^ sck_q;
  wire dck_edge = dck_s ^ dck_q;

  // Clock-loss watchdogs on core_clk; stall limit doubles per step
  logic [CNT_W-1:0] gone_limit, sck_cnt, dck_cnt;
  logic sck_gone_pulse, dck_gone_pulse;
  assign gone_limit = CNT_W'(GONE_BASE) << interp_sel;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_cnt <= '0;
      sck_gone_pulse <= 1'b0;
    end else begin
      sck_gone_pulse <= 1'b0;
      if (sck_edge) begin
        sck_cnt <= '0;
      end else if (sck_cnt < gone_limit) begin
        sck_cnt <= sck_cnt + CNT_W'(1);
        sck_gone_pulse <= (sck_cnt + CNT_W'(1)) == gone_limit;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dck_cnt <= '0;
      dck_gone_pulse <= 1'b0;
    end else begin
      dck_gone_pulse <= 1'b0;
      if (dck_edge) begin
        dck_cnt <= '0;
      end else if (dck_cnt < gone_limit) begin
        dck_cnt <= dck_cnt + CNT_W'(1);
        dck_gone_pulse <= (dck_cnt + CNT_W'(1)) == gone_limit;
      end
    end
  end

  // Serial configuration port: sample on rise, shift out on fall
  port_state_t state;
  logic [4:0] bit_cnt;
  logic [FRAME_BITS-2:0] shift_in;
  logic is_read;
  logic [6:0] addr;
  logic [15:0] read_shadow, read_word;
  logic wr_pulse;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      bit_cnt <= '0;
      shift_in <= '0;
      is_read <= 1'b0;
      addr <= '0;
      read_shadow <= ZERO_WORD;
      wr_pulse <= 1'b0;
      wr_addr <= '0;
      wr_data <= ZERO_WORD;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (!frame_on) begin
        state <= S_IDLE;
        bit_cnt <= '0;
        sdo_oe <= 1'b0;
        sdo <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            state <= S_INSTR;
          end
          S_INSTR: begin
            if (sclk_rise) begin
              shift_in <= {shift_in[FRAME_BITS-3:0], sdi_s};
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'(INSTR_BITS - 1)) begin
                is_read <= shift_in[INSTR_BITS-2];
                addr <= {shift_in[5:0], sdi_s};
                state <= S_DATA;
              end
            end
          end
          S_DATA: begin
            if (is_read && sclk_fall) begin
              if (bit_cnt == 5'(INSTR_BITS)) begin
                sdo <= read_word[DATA_BITS-1];
                read_shadow <= {read_word[DATA_BITS-2:0], 1'b0};
                sdo_oe <= 1'b1;
              end else begin
                sdo <= read_shadow[DATA_BITS-1];
                read_shadow <= {read_shadow[DATA_BITS-2:0], 1'b0};
              end
            end
            if (sclk_rise && bit_cnt != 5'(FRAME_BITS)) begin
              shift_in <= {shift_in[FRAME_BITS-3:0], sdi_s};
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'(FRAME_BITS - 1) && !is_read) begin
                wr_pulse <= 1'b1;
                wr_addr <= addr;
                wr_data <= {shift_in[DATA_BITS-2:0], sdi_s};
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Alarm flags: hardware set beats a same-cycle software clear
  logic sck_gone, dck_gone, clock_lost, mism_a, mism_b;
  logic [15:0] alarm_mask;
  wire st_wr = wr_pulse && wr_addr == ADDR_ALARM_STATUS;
  wire keep_sck = ~(st_wr & ~wr_data[BIT_SAMPLE_CLK_GONE]);
  wire keep_dck = ~(st_wr & ~wr_data[BIT_DATA_CLK_GONE]);
  wire keep_lost = ~(st_wr & ~wr_data[BIT_CLOCK_LOST]);
  wire keep_a = ~(st_wr & ~wr_data[BIT_MISMATCH_A]);
  wire keep_b = ~(st_wr & ~wr_data[BIT_MISMATCH_B]);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_gone <= 1'b0;
      dck_gone <= 1'b0;
      clock_lost <= 1'b0;
      mism_a <= 1'b0;
      mism_b <= 1'b0;
    end else begin
      sck_gone <= sck_gone_pulse | (sck_gone & keep_sck);
      dck_gone <= dck_gone_pulse | (dck_gone & keep_dck);
      clock_lost <= sck_gone_pulse | dck_gone_pulse | (clock_lost & keep_lost);
      mism_a <= (check_a_valid & check_a_mismatch) | (mism_a & keep_a);
      mism_b <= (check_b_valid & check_b_mismatch) | (mism_b & keep_b);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_mask <= MASK_RESET;
    end else if (wr_pulse && wr_addr == ADDR_ALARM_MASK) begin
      alarm_mask <= wr_data;
    end
  end

  // Fuses caught once after reset release; they never change later
  logic [5:0] fuse_q;
  logic fuse_taken;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fuse_q <= '0;
      fuse_taken <= 1'b0;
      force_full_word <= 1'b0;
      force_single_conv <= 1'b0;
      force_resolution <= '0;
    end else begin
      if (!fuse_taken) begin
        fuse_q <= fuse_pins;
        fuse_taken <= 1'b1;
      end
      force_full_word <= fuse_q[FUSE_FULL_WORD];
      force_single_conv <= fuse_q[FUSE_SINGLE_CONV];
      force_resolution <= fuse_q[FUSE_RES_MSB:FUSE_RES_LSB];
    end
  end

  // Register read mux; unused status and readback bits and unmapped addresses read zero, mask reads all 16 bits
  logic [15:0] status_word;
  always_comb begin
    status_word = ZERO_WORD;
    status_word[BIT_SAMPLE_CLK_GONE] = sck_gone;
    status_word[BIT_DATA_CLK_GONE] = dck_gone;
    status_word[BIT_CLOCK_LOST] = clock_lost;
    status_word[BIT_MISMATCH_A] = mism_a;
    status_word[BIT_MISMATCH_B] = mism_b;
    case (addr)
      ADDR_ALARM_STATUS: read_word = status_word;
      ADDR_READBACK: read_word = {temp_word, fuse_q, 2'b00};
      ADDR_ALARM_MASK: read_word = alarm_mask;
      default: read_word = ZERO_WORD;
    endcase
  end

  // Output serializer and external alarm pin
  wire shut_off = clock_lost & ~alarm_mask[MASK_SHUTOFF_BIT];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_serializer_a <= ZERO_WORD;
      output_serializer_b <= ZERO_WORD;
      alarm_pin <= 1'b0;
    end else begin
      output_serializer_a <= shut_off ? MID_SCALE : sample_a;
      output_serializer_b <= shut_off ? MID_SCALE : sample_b;
      alarm_pin <= |(status_word & ~alarm_mask);
    end
  end
endmodule // alarm_status_and_fuse_readback
`default_nettype wire

// ===== common/alarm_fuse_pkg.sv
/*
  Constants for the alarm status and fuse readback block: register
  offsets, field positions, reset values and serial frame layout.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package alarm_fuse_pkg;
  // Serial frame: 8-bit instruction then 16 data bits, MSB first
  localparam int INSTR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = INSTR_BITS + DATA_BITS;
  localparam int INSTR_RW_BIT = 7;
  localparam logic [6:0] ADDR_ALARM_STATUS = 7'h05;
  localparam logic [6:0] ADDR_READBACK = 7'h06;
  localparam logic [6:0] ADDR_ALARM_MASK = 7'h07;
  // Alarm status fields
  localparam int BIT_SAMPLE_CLK_GONE = 7;
  localparam int BIT_DATA_CLK_GONE = 6;
  localparam int BIT_CLOCK_LOST = 5;
  localparam int BIT_MISMATCH_A = 4;
  localparam int BIT_MISMATCH_B = 3;
  // Readback fields
  localparam int TEMP_MSB = 15;
  localparam int TEMP_LSB = 8;
  localparam int FUSE_MSB = 7;
  localparam int FUSE_LSB = 2;
  localparam int FUSE_FULL_WORD = 5;
  localparam int FUSE_SINGLE_CONV = 2;
  localparam int FUSE_RES_MSB = 1;
  localparam int FUSE_RES_LSB = 0;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  // Mask register, mid-scale and zero words
  localparam int MASK_SHUTOFF_BIT = 5;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  localparam logic [15:0] MID_SCALE = 16'h8000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage

// ===== verification/alarm_fuse_sva.sv
/* Port checker for the alarm/fuse block.
   Assumes samples never equal mid-scale. */
`timescale 1ns/1ps
`default_nettype none
module alarm_fuse_sva
  import alarm_fuse_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sdenb_n,
  input wire logic sdo_oe,
  input wire logic [5:0] fuse_pins,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  input wire logic [15:0] output_serializer_a,
  input wire logic [15:0] output_serializer_b,
  input wire logic force_full_word,
  input wire logic force_single_conv,
  input wire logic [1:0] force_resolution
);
  logic [1:0] up;
  // Fuses settle two edges after release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_pass_a: assert property (up != 2'h0 && output_serializer_a != MID_SCALE
    |-> output_serializer_a == $past(sample_a)) else $error("serializer A lost sample");
  chk_pass_b: assert property (up != 2'h0 && output_serializer_b != MID_SCALE
    |-> output_serializer_b == $past(sample_b)) else $error("serializer B lost sample");
  chk_mid_pair: assert property (output_serializer_a == MID_SCALE
    |-> output_serializer_b == MID_SCALE) else $error("serializer B not mid-scale");
  chk_mid_sticks: assert property ($past(output_serializer_a) == MID_SCALE
    && output_serializer_a != MID_SCALE |-> !$past(sdenb_n)) else $error("mid-scale left");
  chk_fuse_full: assert property (up == 2'h3 |-> force_full_word == fuse_pins[5])
    else $error("full word force wrong");
  chk_fuse_single: assert property (up == 2'h3 |-> force_single_conv == fuse_pins[2])
    else $error("single mode force wrong");
  chk_fuse_res: assert property (up == 2'h3 |-> force_resolution == fuse_pins[1:0])
    else $error("resolution force wrong");
  chk_oe_idle: assert property (sdenb_n [*6] |-> !sdo_oe)
    else $error("sdo driven outside frame");
  chk_oe_frame: assert property ($rose(sdo_oe) |-> !sdenb_n)
    else $error("sdo enabled without frame");
  cover property (output_serializer_a == MID_SCALE);
  cover property ($rose(sdo_oe));
  cover property (up == 2'h3 && force_single_conv);
endmodule // alarm_fuse_sva
bind alarm_status_and_fuse_readback alarm_fuse_sva u_sva (.core_clk(core_clk), .rst(rst),
  .sdenb_n(sdenb_n), .sdo_oe(sdo_oe), .fuse_pins(fuse_pins), .sample_a(sample_a),
  .sample_b(sample_b),
  .output_serializer_a(output_serializer_a), .output_serializer_b(output_serializer_b),
  .force_full_word(force_full_word), .force_single_conv(force_single_conv),
  .force_resolution(force_resolution));
`default_nettype wire

// ===== verification/alarm_status_and_fuse_readback_bench.sv
/* Self-checking bench: serial port, clock probes, checks, fuses.
   Assumes package, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module alarm_status_and_fuse_readback_bench;
  import alarm_fuse_pkg::*;
  int half = 20;
  logic core_clk = 1'b0, rst = 1'b1, sclk = 1'b0, sdenb_n = 1'b1, sdi = 1'b0, sdo, sdo_oe;
  logic sp = 1'b0, dp = 1'b0, stop_s = 1'b0, stop_d = 1'b0, alarm_pin, ffw, fsc;
  logic cav = 1'b0, cam = 1'b0, cbv = 1'b0, cbm = 1'b0;
  logic [1:0] interp_sel = 2'h0, fres;
  logic [7:0] temp_code = 8'h5A;
  logic [5:0] fuse_pins = 6'h00;
  logic [5:0] fl [3] = '{6'h22, 6'h01, 6'h24};
  logic [15:0] sample_a = 16'h1234, sample_b = 16'h0ABC, oa, ob, rd;
  logic [15:0] prev_a = 16'h0000, prev_b = 16'h0000;
  int bad_count = 0, check_count = 0, cyc = 0;
  alarm_status_and_fuse_readback u_dut (.core_clk(core_clk), .rst(rst), .sclk(sclk),
    .sdenb_n(sdenb_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sample_clk_probe(sp),
    .data_clk_probe(dp), .interp_sel(interp_sel), .check_a_valid(cav),
    .check_a_mismatch(cam), .check_b_valid(cbv), .check_b_mismatch(cbm),
    .temp_code(temp_code), .fuse_pins(fuse_pins), .sample_a(sample_a), .sample_b(sample_b),
    .output_serializer_a(oa), .output_serializer_b(ob), .alarm_pin(alarm_pin),
    .force_full_word(ffw), .force_single_conv(fsc), .force_resolution(fres));
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    sp <= stop_s ? sp : ~sp;
    dp <= stop_d ? dp : ~dp;
    // Samples alternate so a wrong serializer latency shows
    sample_a <= sample_a ^ 16'h0101;
    sample_b <= sample_b ^ 16'h0101;
    prev_a <= sample_a;
    prev_b <= sample_b;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Slow sclk keeps the synchronisers honest
  task xfer(input logic r, input logic [6:0] a, input logic [15:0] w);
    logic [23:0] f;
    f = {r, a, w};
    sdenb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      wait_n(half);
      sclk <= 1'b1;
      if (i < 16)
        rd[i] = sdo;
      wait_n(half);
      sclk <= 1'b0;
    end
    wait_n(half);
    sdenb_n <= 1'b1;
    wait_n(8);
  endtask
  task rreg(input logic [6:0] a, input logic [15:0] e);
    xfer(1'b1, a, 16'h0000);
    chk("reg", e, rd);
  endtask
  // Comparator results as one-cycle pulses; word alignment is upstream
  task pulse(input logic [3:0] v);
    {cav, cam, cbv, cbm} <= v;
    wait_n(1);
    {cav, cam, cbv, cbm} <= 4'h0;
    wait_n(2);
  endtask
  task t_fuses;
    foreach (fl[k]) begin
      fuse_pins <= fl[k];
      rst <= 1'b1;
      wait_n(6);
      rst <= 1'b0;
      wait_n(4);
      chk("full", {15'h0, fl[k][5]}, {15'h0, ffw});
      chk("single", {15'h0, fl[k][2]}, {15'h0, fsc});
      chk("res", {14'h0, fl[k][1:0]}, {14'h0, fres});
    end
    half = 100;
    rreg(ADDR_READBACK, {temp_code, fl[2], 2'b00});
    half = 20;
    $display("fuse test done");
  endtask
  task t_regs;
    rreg(ADDR_ALARM_STATUS, 16'h0000);
    rreg(ADDR_ALARM_MASK, MASK_RESET);
    rreg(7'h10, 16'h0000);
    xfer(1'b0, ADDR_READBACK, 16'hFFFF);
    rreg(ADDR_READBACK, {temp_code, fl[2], 2'b00});
    xfer(1'b0, ADDR_ALARM_STATUS, 16'hFFFF);
    rreg(ADDR_ALARM_STATUS, 16'h0000);
    xfer(1'b0, ADDR_ALARM_MASK, 16'h0000);
    $display("register test done");
  endtask
  task t_loss;
    interp_sel <= 2'h2;
    stop_s <= 1'b1;
    wait_n(20);
    chk("early", prev_a, oa);
    wait_n(40);
    chk("mid a", MID_SCALE, oa);
    chk("mid b", MID_SCALE, ob);
    chk("alarm", 16'h1, {15'h0, alarm_pin});
    stop_s <= 1'b0;
    wait_n(10);
    chk("sticky", MID_SCALE, oa);
    rreg(ADDR_ALARM_STATUS, 16'h00A0);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'hFFDF);
    chk("resume", prev_a, oa);
    chk("resume b", prev_b, ob);
    rreg(ADDR_ALARM_STATUS, 16'h0080);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'h0000);
    stop_d <= 1'b1;
    wait_n(60);
    stop_d <= 1'b0;
    rreg(ADDR_ALARM_STATUS, 16'h0060);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'h0000);
    xfer(1'b0, ADDR_ALARM_MASK, 16'h0020);
    stop_s <= 1'b1;
    wait_n(60);
    stop_s <= 1'b0;
    chk("masked", prev_a, oa);
    chk("pin", 16'h1, {15'h0, alarm_pin});
    rreg(ADDR_ALARM_STATUS, 16'h00A0);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'h0000);
    $display("clock loss test done");
  endtask
  // Stall limit scales with interpolation: 64 cycles at 3, 8 at 0
  task t_interp;
    interp_sel <= 2'h3;
    stop_d <= 1'b1;
    wait_n(50);
    stop_d <= 1'b0;
    rreg(ADDR_ALARM_STATUS, 16'h0000);
    interp_sel <= 2'h0;
    stop_d <= 1'b1;
    wait_n(20);
    stop_d <= 1'b0;
    rreg(ADDR_ALARM_STATUS, 16'h0060);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'h0000);
    $display("interpolation test done");
  endtask
  task t_mism;
    pulse(4'h8);
    pulse(4'h5);
    rreg(ADDR_ALARM_STATUS, 16'h0000);
    pulse(4'hC);
    rreg(ADDR_ALARM_STATUS, 16'h0010);
    pulse(4'h3);
    rreg(ADDR_ALARM_STATUS, 16'h0018);
    xfer(1'b0, ADDR_ALARM_STATUS, 16'hFFEF);
    rreg(ADDR_ALARM_STATUS, 16'h0008);
    $display("mismatch test done");
  endtask
  initial begin
    t_fuses();
    t_regs();
    t_loss();
    t_interp();
    t_mism();
    test_done();
  end
endmodule // alarm_status_and_fuse_readback_bench
`default_nettype wire
